//--- probe_rig.sv
// Test rig model: drives the internal sources and probes the pins through pull-downs
`timescale 1ns/10ps
module probe_rig (
  // Settings from the bench
  input wire logic [6:0] src_set,
  input wire logic [4:0] ana_set,
  // Sources into the block
  output test_route_pkg::test_sources_t sources,
  output logic [4:0] ana,
  // Probe pins
  input wire test_route_pkg::probe_out_t pin_one,
  input wire test_route_pkg::probe_out_t pin_two,
  output logic wire_one,
  output logic wire_two
);
  assign sources = test_route_pkg::test_sources_t'(src_set);
  assign ana = ana_set;
  // A released pin falls to the pull-down level
  assign wire_one = pin_one.drive_n ? 1'b0 : pin_one.digital;
  assign wire_two = pin_two.drive_n ? 1'b0 : pin_two.digital;
endmodule

//--- test_route.sv
// Self-test signature, test bus routing, probe pin selection and PRBS test source
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "test_route_defines.svh"

// Overview of operation
// - Self-test leaves fixed 64-byte signature
// - 5-bit selector picks group for D1-D6
// - Group 07h routes receiver signals
// - Group 0Dh routes oscillator signals
// - Each probe pin has 4-bit source
// - Low codes: hi-z, DAC, analog sources
// - High codes: levels, activity, test bit
// - Upper nibble pin one, lower pin two
// - DAC source follows own 6-bit register
// - 106 kBd receive activity excludes start bits
// - 106 kBd transmit activity includes start bits
// - Higher rates: activity excludes start bits
// - 3-bit selector picks single test line
// - FFh puts test bit on both pins
// - PRBS9/PRBS15 sent on transmit command
module test_route (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Internal sources, asynchronous to this clock
  input wire test_route_pkg::test_sources_t sources,
  input wire logic correlation_signal,
  input wire logic minimum_level_signal,
  input wire logic adc_i_sign,
  input wire logic adc_q_sign,
  input wire logic subcarrier_seen,
  // Frame phase from the coder: busy, start bit, 106 kBd mode
  input wire logic tx_busy,
  input wire logic tx_start_bit,
  input wire logic rx_busy,
  input wire logic rx_start_bit,
  input wire logic rate_106,
  // Test pins
  output logic [5:0] test_bus_pins,
  output test_route_pkg::probe_out_t probe_pin_one,
  output test_route_pkg::probe_out_t probe_pin_two,
  // PRBS stream to the transmitter
  output logic prbs_bit,
  output logic prbs_active
);
  // Synchronised sources
  logic [11:0] sync1_r, sync2_r;
  always_ff @(posedge clock) begin
    sync1_r <= {sources, correlation_signal, minimum_level_signal, adc_i_sign, adc_q_sign,
      subcarrier_seen};
    sync2_r <= sync1_r;
  end
  test_route_pkg::test_sources_t src;
  logic corr_s, minl_s, adci_s, adcq_s, subc_s;
  assign {src, corr_s, minl_s, adci_s, adcq_s, subc_s} = sync2_r;

  // Registers
  logic [7:0] auto_test_control_reg;
  logic [7:0] test_select_first_reg, test_select_second_reg, analog_probe_select_reg;
  logic [5:0] probe_dac_one_value, probe_dac_two_value;
  logic aw_hold_r, w_hold_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_go;
  logic [3:0] cmd_code;
  assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign cmd_code = w_data_r[3:0];
  // Ready outputs are flops; holding flags are their inverses
  assign aw_hold_r = !s_axi_awready;
  assign w_hold_r = !s_axi_wready;

  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_r <= `OFS_CMD && aw_addr_r[1:0] == 2'h0) ? `RESP_OKAY
          : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      auto_test_control_reg <= 8'h00;
      test_select_first_reg <= 8'h00;
      test_select_second_reg <= 8'h00;
      analog_probe_select_reg <= 8'h00;
      probe_dac_one_value <= 6'h00;
      probe_dac_two_value <= 6'h00;
    end else if (wr_go && w_strb_r[0]) begin
      unique case (aw_addr_r)
        `OFS_AUTO_TEST: auto_test_control_reg <= w_data_r[7:0];
        `OFS_TSEL_ONE: test_select_first_reg <= w_data_r[7:0];
        `OFS_TSEL_TWO: test_select_second_reg <= w_data_r[7:0];
        `OFS_PROBE_SEL: analog_probe_select_reg <= w_data_r[7:0];
        `OFS_DAC_ONE: probe_dac_one_value <= w_data_r[5:0];
        `OFS_DAC_TWO: probe_dac_two_value <= w_data_r[5:0];
        default: ;
      endcase
    end
  end

  // Self-test: armed value plus CRC command fills the buffer with the signature
  localparam logic [7:0] SIG [0:63] = '{
    8'h00, 8'heb, 8'h66, 8'hba, 8'h57, 8'hbf, 8'h23, 8'h95, 8'hd0, 8'he3, 8'h0d, 8'h3d,
    8'h27, 8'h89, 8'h5c, 8'hde, 8'h9d, 8'h3b, 8'ha7, 8'h00, 8'h21, 8'h5b, 8'h89, 8'h82,
    8'h51, 8'h3a, 8'heb, 8'h02, 8'h0c, 8'ha5, 8'h00, 8'h49, 8'h7c, 8'h84, 8'h4d, 8'hb3,
    8'hcc, 8'hd2, 8'h1b, 8'h81, 8'h5d, 8'h48, 8'h76, 8'hd5, 8'h71, 8'h61, 8'h21, 8'ha9,
    8'h86, 8'h96, 8'h83, 8'h38, 8'hcf, 8'h9d, 8'h5b, 8'h6d, 8'hdc, 8'h15, 8'hba, 8'h3e,
    8'h7d, 8'h95, 8'h3b, 8'h2f};
  test_route_pkg::selftest_state_t st_r;
  logic [7:0] fifo_mem [0:63];
  logic [6:0] fill_r;
  logic [5:0] rd_ptr_r;
  logic crc_cmd, fifo_pop;
  assign crc_cmd = wr_go && w_strb_r[0] && aw_addr_r == `OFS_CMD && cmd_code == `CMD_CRC;
  assign fifo_pop = s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFS_FIFO
    && fill_r != 7'h00 && st_r != test_route_pkg::ST_FILL;

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= test_route_pkg::ST_IDLE;
      fill_r <= 7'h00;
      rd_ptr_r <= 6'h00;
    end else begin
      unique case (st_r)
        test_route_pkg::ST_IDLE, test_route_pkg::ST_DONE: begin
          if (crc_cmd && auto_test_control_reg == `SELFTEST_ARM) begin
            st_r <= test_route_pkg::ST_FILL;
            fill_r <= 7'h00;
            rd_ptr_r <= 6'h00;
          end else if (fifo_pop) begin
            fill_r <= fill_r - 7'h01;
            rd_ptr_r <= rd_ptr_r + 6'h01;
          end
        end
        test_route_pkg::ST_FILL: begin
          fill_r <= fill_r + 7'h01;
          if (fill_r == `FIFO_DEPTH - 7'h01) st_r <= test_route_pkg::ST_DONE;
        end
        default: st_r <= test_route_pkg::ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (st_r == test_route_pkg::ST_FILL) fifo_mem[fill_r[5:0]] <= SIG[fill_r[5:0]];
  end

  // Read channel
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0;
    unique case (s_axi_araddr)
      `OFS_AUTO_TEST: rd_val = {24'h0, auto_test_control_reg};
      `OFS_TSEL_ONE: rd_val = {24'h0, test_select_first_reg};
      `OFS_TSEL_TWO: rd_val = {24'h0, test_select_second_reg};
      `OFS_PROBE_SEL: rd_val = {24'h0, analog_probe_select_reg};
      `OFS_DAC_ONE: rd_val = {26'h0, probe_dac_one_value};
      `OFS_DAC_TWO: rd_val = {26'h0, probe_dac_two_value};
      `OFS_STATUS: rd_val = {23'h0, prbs_active, fill_r, st_r == test_route_pkg::ST_DONE};
      `OFS_FIFO: rd_val = {24'h0, fifo_pop ? fifo_mem[rd_ptr_r] : 8'h00};
      default: rd_val = 32'h0;
    endcase
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_arready <= 1'b0;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= (s_axi_araddr <= `OFS_FIFO && s_axi_araddr[1:0] == 2'h0) ? `RESP_OKAY
        : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Oscillator divided by eight, counted on each rising edge of the synced clock
  logic [2:0] div_r;
  logic osc_prev_r;
  always_ff @(posedge clock) begin
    if (rst) begin
      div_r <= 3'h0;
      osc_prev_r <= 1'b0;
    end else begin
      osc_prev_r <= src.osc_raw;
      if (src.osc_raw && !osc_prev_r) div_r <= div_r + 3'h1;
    end
  end

  // Test bus group decode
  function automatic logic [5:0] group_decode(input logic [4:0] sel,
      input test_route_pkg::test_sources_t s, input logic div8);
    group_decode = 6'h00;
    if (sel == `GRP_RX)
      group_decode = {s.rx_data, s.rx_coll, s.rx_valid, s.rx_stop, s.rx_reset, 1'b0};
    else if (sel == `GRP_OSC)
      group_decode = {s.osc_stable, div8, 2'b00, s.osc_raw, 1'b0};
  endfunction
  logic [5:0] bus_now;
  logic test_line;
  assign bus_now = group_decode(test_select_second_reg[4:0], src, div_r[`DIV_EIGHT_BIT]);
  // Codes 0 and 7 name no line and give a quiet low
  assign test_line = (test_select_first_reg[2:0] == 3'h0 || test_select_first_reg[2:0] == 3'h7) ? 1'b0
    : bus_now[test_select_first_reg[2:0] - 3'h1];
  always_ff @(posedge clock) begin
    if (rst) test_bus_pins <= 6'h00;
    else test_bus_pins <= bus_now;
  end

  // Activity signals per rate
  logic tx_act, rx_act;
  assign tx_act = tx_busy && (rate_106 || !tx_start_bit);
  assign rx_act = rx_busy && !rx_start_bit;

  // Probe pin source decode
  function automatic test_route_pkg::probe_out_t probe_decode(input logic [3:0] code,
      input logic [5:0] dac, input logic [4:0] an, input logic [3:0] dig);
    probe_decode = '{level: 6'h00, digital: 1'b0, drive_n: 1'b0};
    unique case (code)
      `SRC_HIZ: probe_decode.drive_n = 1'b1;
      `SRC_DAC: probe_decode.level = dac;
      `SRC_CORR: probe_decode.level = {6{an[4]}};
      `SRC_MINLVL: probe_decode.level = {6{an[3]}};
      `SRC_ADC_I: probe_decode.level = {6{an[2]}};
      `SRC_ADC_Q: probe_decode.level = {6{an[1]}};
      `SRC_HIGH: probe_decode.digital = 1'b1;
      `SRC_LOW: probe_decode.digital = 1'b0;
      `SRC_TX: probe_decode.digital = dig[3];
      `SRC_RX: probe_decode.digital = dig[2];
      `SRC_SUBC: probe_decode.digital = dig[1];
      `SRC_TBIT: probe_decode.digital = dig[0];
      default: probe_decode.drive_n = 1'b1;
    endcase
  endfunction
  logic [4:0] an_bits;
  logic [3:0] dig_bits;
  assign an_bits = {corr_s, minl_s, adci_s, adcq_s, 1'b0};
  assign dig_bits = {tx_act, rx_act, subc_s, test_line};
  always_ff @(posedge clock) begin
    if (rst) begin
      probe_pin_one <= '{level: 6'h00, digital: 1'b0, drive_n: 1'b1};
      probe_pin_two <= '{level: 6'h00, digital: 1'b0, drive_n: 1'b1};
    end else begin
      probe_pin_one <= probe_decode(analog_probe_select_reg[7:4], probe_dac_one_value,
        an_bits, dig_bits);
      probe_pin_two <= probe_decode(analog_probe_select_reg[3:0], probe_dac_two_value,
        an_bits, dig_bits);
    end
  end

  // PRBS source: mode in second test select bits 6:5, started by transmit command
  logic [14:0] lfsr_r;
  logic [1:0] prbs_mode;
  logic tx_cmd;
  assign prbs_mode = test_select_second_reg[6:5];
  assign tx_cmd = wr_go && w_strb_r[0] && aw_addr_r == `OFS_CMD && cmd_code == `CMD_TRANSMIT;
  always_ff @(posedge clock) begin
    if (rst) begin
      lfsr_r <= 15'h7fff;
      prbs_active <= 1'b0;
      prbs_bit <= 1'b0;
    end else begin
      if (tx_cmd && (prbs_mode == `PRBS_9 || prbs_mode == `PRBS_15)) begin
        prbs_active <= 1'b1;
        lfsr_r <= 15'h7fff;
      end else if (prbs_mode == `PRBS_NONE) begin
        prbs_active <= 1'b0;
      end
      if (prbs_active) begin
        if (prbs_mode == `PRBS_9) begin
          lfsr_r <= {6'h00, lfsr_r[7:0], lfsr_r[8] ^ lfsr_r[4]};
          prbs_bit <= lfsr_r[8];
        end else begin
          lfsr_r <= {lfsr_r[13:0], lfsr_r[14] ^ lfsr_r[13]};
          prbs_bit <= lfsr_r[14];
        end
      end
    end
  end

  // Checks
  fill_count_a: assert property (@(posedge clock) disable iff (rst)
    $rose(st_r == test_route_pkg::ST_FILL) |-> ##64 (fill_r == 7'h40))
    else $error("self-test did not leave 64 bytes");
  grp_rx_a: assert property (@(posedge clock) disable iff (rst)
    test_select_second_reg[4:0] == `GRP_RX |=> test_bus_pins[5] == $past(src.rx_data))
    else $error("receive group not routed");
  grp_rsv_a: assert property (@(posedge clock) disable iff (rst)
    !(test_select_second_reg[4:0] inside {`GRP_RX, `GRP_OSC}) |=> test_bus_pins == 6'h00)
    else $error("reserved group drives pins");
  probe_hiz_a: assert property (@(posedge clock) disable iff (rst)
    analog_probe_select_reg[7:4] == `SRC_HIZ |=> probe_pin_one.drive_n)
    else $error("pin one not released");
  probe_high_a: assert property (@(posedge clock) disable iff (rst)
    analog_probe_select_reg[3:0] == `SRC_HIGH |=> probe_pin_two.digital && !probe_pin_two.drive_n)
    else $error("pin two not high");
  probe_dac_a: assert property (@(posedge clock) disable iff (rst)
    analog_probe_select_reg[7:4] == `SRC_DAC |=> probe_pin_one.level == $past(probe_dac_one_value))
    else $error("pin one not following its dac");
  probe_both_a: assert property (@(posedge clock) disable iff (rst)
    analog_probe_select_reg == 8'hff |=> probe_pin_one.digital == probe_pin_two.digital)
    else $error("test bit differs on pins");
  prbs_start_a: assert property (@(posedge clock) disable iff (rst)
    tx_cmd && prbs_mode == `PRBS_15 |=> prbs_active)
    else $error("prbs not started");
  selftest_cv: cover property (@(posedge clock) st_r == test_route_pkg::ST_DONE);
  tbit_cv: cover property (@(posedge clock) analog_probe_select_reg == 8'hff);
  prbs_cv: cover property (@(posedge clock) prbs_active);
endmodule

//--- test_route_defines.svh
// Register offsets, field positions, codes and timing counts of the test routing block
`ifndef TEST_ROUTE_DEFINES_SVH
`define TEST_ROUTE_DEFINES_SVH
`define OFS_AUTO_TEST 8'h00
`define OFS_TSEL_ONE 8'h04
`define OFS_TSEL_TWO 8'h08
`define OFS_PROBE_SEL 8'h0c
`define OFS_DAC_ONE 8'h10
`define OFS_DAC_TWO 8'h14
`define OFS_CMD 8'h18
`define OFS_STATUS 8'h1c
`define OFS_FIFO 8'h20
`define SELFTEST_ARM 8'h09
`define GRP_RX 5'h07
`define GRP_OSC 5'h0d
`define SRC_HIZ 4'h0
`define SRC_DAC 4'h1
`define SRC_CORR 4'h2
`define SRC_MINLVL 4'h4
`define SRC_ADC_I 4'h5
`define SRC_ADC_Q 4'h6
`define SRC_HIGH 4'ha
`define SRC_LOW 4'hb
`define SRC_TX 4'hc
`define SRC_RX 4'hd
`define SRC_SUBC 4'he
`define SRC_TBIT 4'hf
`define CMD_CRC 4'h3
`define CMD_TRANSMIT 4'h4
`define CMD_CONFIG 4'h1
`define PRBS_NONE 2'h0
`define PRBS_9 2'h1
`define PRBS_15 2'h2
`define FIFO_DEPTH 7'h40
`define SIG_SEED 8'h00
`define DAC_MAX 6'h3f
`define DIV_EIGHT_BIT 2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

//--- test_route_pkg.sv
// Types shared by the test routing block
package test_route_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FILL = 2'b01,
    ST_DONE = 2'b10
  } selftest_state_t;
  typedef struct packed {
    logic rx_data;
    logic rx_coll;
    logic rx_valid;
    logic rx_stop;
    logic rx_reset;
    logic osc_stable;
    logic osc_raw;
  } test_sources_t;
  typedef struct packed {
    logic [5:0] level;
    logic digital;
    logic drive_n;
  } probe_out_t;
endpackage

//--- test_signal_routing_selftest_tb_top.sv
// Self-checking bench of the test routing block
`timescale 1ns/10ps
`include "test_route_defines.svh"
module test_signal_routing_selftest_tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, prbs_bit, prbs_active, wire_one, wire_two;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic tx_busy = 0, tx_start_bit = 0, rx_busy = 0, rx_start_bit = 0, rate_106 = 0;
  logic [6:0] src_set = 7'h00;
  logic [4:0] ana_set = 5'h00, ana;
  logic [5:0] test_bus_pins;
  test_route_pkg::test_sources_t sources;
  test_route_pkg::probe_out_t pin_one, pin_two;
  int n_fail = 0;
  int checks = 0;

  always #2.5 clock = ~clock;

  test_route i_test_route (.clock(clock), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sources(sources), .correlation_signal(ana[4]),
    .minimum_level_signal(ana[3]), .adc_i_sign(ana[2]), .adc_q_sign(ana[1]),
    .subcarrier_seen(ana[0]), .tx_busy(tx_busy), .tx_start_bit(tx_start_bit),
    .rx_busy(rx_busy), .rx_start_bit(rx_start_bit), .rate_106(rate_106),
    .test_bus_pins(test_bus_pins), .probe_pin_one(pin_one), .probe_pin_two(pin_two),
    .prbs_bit(prbs_bit), .prbs_active(prbs_active));

  probe_rig i_probe_rig (.src_set(src_set), .ana_set(ana_set), .sources(sources), .ana(ana),
    .pin_one(pin_one), .pin_two(pin_two), .wire_one(wire_one), .wire_two(wire_two));

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task final_report;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task wt(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    logic aw, w, got;
    @(posedge clock);
    n = 0;
    aw = 1;
    w = 1;
    got = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!got && n < 100) begin
      @(posedge clock);
      n++;
      if (aw && s_axi_awready === 1'b1) begin
        aw = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) begin
        got = 1;
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    if (!got) n_fail++;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    logic got;
    @(posedge clock);
    n = 0;
    got = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got && n < 100) begin
      @(posedge clock);
      n++;
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        got = 1;
        rd_data = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
    if (!got) n_fail++;
  endtask

  task t_reset;
    chk("pins at reset", 6'h00, test_bus_pins);
    chk("probe release", 2'b11, {pin_one.drive_n, pin_two.drive_n});
  endtask

  task automatic t_groups;
    logic e;
    wr(`OFS_TSEL_TWO, {3'h0, `GRP_RX});
    for (int i = 0; i < 2; i++) begin
      src_set <= i ? 7'h2b : 7'h54;
      wt(4);
      chk("rx group", {src_set[6:2], 1'b0}, test_bus_pins);
    end
    wr(`OFS_TSEL_TWO, {3'h0, `GRP_OSC});
    for (int i = 0; i < 2; i++) begin
      src_set <= i ? 7'h02 : 7'h01;
      wt(4);
      chk("osc group", i ? 6'h20 : 6'h02, test_bus_pins & 6'h2f);
    end
    e = test_bus_pins[4];
    repeat (4) begin
      src_set <= 7'h01;
      wt(4);
      src_set <= 7'h00;
      wt(4);
    end
    chk("osc div eight", !e, test_bus_pins[4]);
  endtask

  task automatic t_codes;
    logic e;
    ana_set <= 5'h1f;
    src_set <= 7'h40;
    rate_106 <= 1'b1;
    tx_busy <= 1'b1;
    rx_busy <= 1'b1;
    wr(`OFS_TSEL_TWO, {3'h0, `GRP_RX});
    wr(`OFS_TSEL_ONE, 8'h06);
    for (int c = 0; c < 16; c++) begin
      if (c != 1) begin
        wr(`OFS_PROBE_SEL, {c[3:0], c[3:0]});
        wt(4);
        e = (16'hf400 >> c) & 1;
        if (c inside {2, 4, 5, 6}) chk("analog level", 12'hfff, {pin_one.level, pin_two.level});
        else chk("probe wires", {2{e}}, {wire_one, wire_two});
      end
    end
    src_set <= 7'h00;
    wt(4);
    chk("test line low", 2'b00, {wire_one, wire_two});
    wr(`OFS_PROBE_SEL, {`SRC_HIGH, `SRC_LOW});
    wt(4);
    chk("nibble order", 2'b10, {wire_one, wire_two});
    wr(`OFS_TSEL_ONE, 8'h07);
    wr(`OFS_PROBE_SEL, 8'hff);
    src_set <= 7'h7f;
    wt(4);
    chk("reserved line", 2'b00, {wire_one, wire_two});
    src_set <= 7'h00;
  endtask

  task automatic t_dac;
    wr(`OFS_PROBE_SEL, {`SRC_DAC, `SRC_DAC});
    for (int i = 0; i < 2; i++) begin
      wr(`OFS_DAC_ONE, i ? 8'h15 : {2'h0, `DAC_MAX});
      wr(`OFS_DAC_TWO, i ? 8'h2a : 8'h00);
      wt(4);
      chk("dac one", {i ? 6'h15 : 6'h3f, 1'b0}, {pin_one.level, pin_one.drive_n});
      chk("dac two", {i ? 6'h2a : 6'h00, 1'b0}, {pin_two.level, pin_two.drive_n});
    end
  endtask

  task automatic t_activity;
    wr(`OFS_PROBE_SEL, {`SRC_TX, `SRC_RX});
    for (int i = 0; i < 16; i++) begin
      tx_busy <= i[3];
      rx_busy <= i[3];
      rate_106 <= i[2];
      tx_start_bit <= i[1];
      rx_start_bit <= i[0];
      wt(2);
      chk("tx activity", i[3] & (i[2] | !i[1]), wire_one);
      chk("rx activity", i[3] & !i[0], wire_two);
    end
  endtask

  task t_errors;
    wr(8'h24, 8'h5a);
    chk("unmapped write", `RESP_SLVERR, rs);
    rd(8'h24);
    chk("unmapped read resp", `RESP_SLVERR, rs);
    chk("unmapped read data", 32'h0, rd_data);
  endtask

  task automatic t_selftest;
    int n;
    wr(`OFS_CMD, {4'h0, `CMD_CONFIG});
    wr(`OFS_AUTO_TEST, `SELFTEST_ARM);
    wr(`OFS_FIFO, 8'h00);
    wr(`OFS_CMD, {4'h0, `CMD_CRC});
    n = 0;
    rd_data = 32'h0;
    while (rd_data[0] !== 1'b1 && n < 200) begin
      rd(`OFS_STATUS);
      n++;
    end
    chk("fill", `FIFO_DEPTH, rd_data[7:1]);
    rd(`OFS_FIFO);
    chk("first byte", `SIG_SEED, rd_data[7:0]);
    repeat (63) rd(`OFS_FIFO);
    rd(`OFS_STATUS);
    chk("drained", 7'h00, rd_data[7:1]);
  endtask

  task automatic t_prbs;
    logic s0, s1;
    for (int m = 1; m < 3; m++) begin
      wr(`OFS_TSEL_TWO, {1'b0, m[1:0], `GRP_RX});
      wr(`OFS_CMD, {4'h0, `CMD_TRANSMIT});
      s0 = 0;
      s1 = 0;
      repeat (40) begin
        @(posedge clock);
        if (prbs_bit === 1'b0) s0 = 1;
        if (prbs_bit === 1'b1) s1 = 1;
      end
      chk("prbs run", 3'b111, {prbs_active, s0, s1});
    end
    wr(`OFS_TSEL_TWO, 8'h00);
    wt(3);
    chk("prbs stop", 1'b0, prbs_active);
  endtask

  initial begin
    wt(2);
    rst <= 1'b0;
    t_reset;
    t_groups;
    t_codes;
    t_dac;
    t_activity;
    t_errors;
    t_selftest;
    t_prbs;
    final_report;
  end

  initial begin
    #100000;
    n_fail++;
    final_report;
  end
endmodule
